// ===== giwp_pkg.sv
/*
 * Constants for the interrupt and wake capable port: register offsets,
 * reset values, pin count and the open-drain pin mask.
 * Assumes a byte-addressed APB slave with one 32-bit word per register.
 */
package giwp_pkg;

	localparam int unsigned PIN_COUNT = 32;
	localparam int unsigned ADDR_W    = 8;

	// ------------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] OFF_PORT_ENABLE      = 8'h00;
	localparam logic [7:0] OFF_PORT_ENABLE_SET  = 8'h04;
	localparam logic [7:0] OFF_PORT_ENABLE_CLR  = 8'h08;
	localparam logic [7:0] OFF_OUTPUT_ENABLE    = 8'h0C;
	localparam logic [7:0] OFF_OUTPUT_ENABLE_SET = 8'h10;
	localparam logic [7:0] OFF_OUTPUT_ENABLE_CLR = 8'h14;
	localparam logic [7:0] OFF_OUTPUT_DATA      = 8'h18;
	localparam logic [7:0] OFF_OUTPUT_SET       = 8'h1C;
	localparam logic [7:0] OFF_OUTPUT_CLEAR     = 8'h20;
	localparam logic [7:0] OFF_PIN_INPUT        = 8'h24;
	localparam logic [7:0] OFF_IRQ_TRIGGER_MODE = 8'h28;
	localparam logic [7:0] OFF_IRQ_POLARITY     = 8'h2C;
	localparam logic [7:0] OFF_IRQ_CHANNEL_SEL  = 8'h30;
	localparam logic [7:0] OFF_IRQ_ENABLE       = 8'h34;
	localparam logic [7:0] OFF_IRQ_ENABLE_SET   = 8'h38;
	localparam logic [7:0] OFF_IRQ_ENABLE_CLEAR = 8'h3C;
	localparam logic [7:0] OFF_IRQ_STATUS_A     = 8'h40;
	localparam logic [7:0] OFF_IRQ_STATUS_B     = 8'h44;
	localparam logic [7:0] OFF_IRQ_CLEAR        = 8'h48;
	localparam logic [7:0] OFF_WAKE_ENABLE      = 8'h4C;
	localparam logic [7:0] OFF_WAKE_ENABLE_SET  = 8'h50;
	localparam logic [7:0] OFF_WAKE_ENABLE_CLEAR = 8'h54;
	localparam logic [7:0] OFF_OPEN_DRAIN_SEL   = 8'h58;

	// ------------------------------------------------------------------
	// Reset values and masks
	// ------------------------------------------------------------------
	localparam logic [31:0] RST_ZERO          = 32'h0000_0000;
	localparam logic [31:0] RST_PORT_ENABLE   = 32'hFF00_FFFF;
	localparam logic [31:0] OPEN_DRAIN_MASK   = 32'h0000_FFFF;

endpackage

// ===== giwp_port.sv
/*
 * Interrupt and wake capable 32-pin port with APB register access.
 * Assumes pins are already synchronous to mclk, and an APB master that
 * holds each request until pready is seen high in the access phase.
 */
// The APB register port was decided locally.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Output-clear write clears written-one output bits
// - Pin-input register returns live pin levels
// - Trigger-mode bit: zero level, one edge
// - Polarity bit: zero falling/low, one rising/high
// - Channel-select bit one routes to channel B
// - Enable gates only pending set, not output
// - Enable set/clear registers, write-only, one-bits act
// - Status A/B show pending, cleared only by clear
// - Irq-clear clears pending and edge detector flops
// - Wake-enabled pin edge of polarity raises wake
// - Wake-enable set/clear registers, write-only
// - Open-drain only on pins 15..0, first port
// - Drive data only when enable and output-enable
// - Output-enable cleared tri-states, input still readable
// - Enables and data writable direct or set/clear
// - Interrupts independent of enable and output-enable
// - Irq-clear re-arms rising and falling edge flops
// - Edge detectors latch pin transitions
// - Wake independent of port and output enables
// - Channels A and B are separate request lines
// - Register bit n maps to pin n
// - All bits reset to zero unless specified
module giwp_port #(
	parameter bit          FIRST_PORT     = 1'b1,
	parameter logic [31:0] PORT_EN_RESET  = giwp_pkg::RST_PORT_ENABLE
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic [31:0] pinIn,
	output logic [31:0]      pinOut,
	output logic [31:0]      pinOe,
	output logic             irqChanA,
	output logic             irqChanB,
	output logic             wakeReq
);

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	logic [31:0] portEn_r;
	logic [31:0] outEn_r;
	logic [31:0] outData_r;
	logic [31:0] trigMode_r;
	logic [31:0] polarity_r;
	logic [31:0] chanSel_r;
	logic [31:0] irqEn_r;
	logic [31:0] wakeEn_r;
	logic [31:0] openDrain_r;
	logic [31:0] pending_r;
	logic [31:0] riseDet_r;
	logic [31:0] fallDet_r;
	logic [31:0] pinPrev_r;
	logic [31:0] prdata_r;
	logic [31:0] pinOut_r;
	logic [31:0] pinOe_r;
	logic        wakeReq_r;

	wire setupPh = psel & ~penable;
	wire accessPh = psel & penable;
	wire wrAcc = accessPh & pwrite;

	wire hEn     = paddr == giwp_pkg::OFF_PORT_ENABLE;
	wire hEnSet  = paddr == giwp_pkg::OFF_PORT_ENABLE_SET;
	wire hEnClr  = paddr == giwp_pkg::OFF_PORT_ENABLE_CLR;
	wire hOe     = paddr == giwp_pkg::OFF_OUTPUT_ENABLE;
	wire hOeSet  = paddr == giwp_pkg::OFF_OUTPUT_ENABLE_SET;
	wire hOeClr  = paddr == giwp_pkg::OFF_OUTPUT_ENABLE_CLR;
	wire hOut    = paddr == giwp_pkg::OFF_OUTPUT_DATA;
	wire hOutSet = paddr == giwp_pkg::OFF_OUTPUT_SET;
	wire hOutClr = paddr == giwp_pkg::OFF_OUTPUT_CLEAR;
	wire hPin    = paddr == giwp_pkg::OFF_PIN_INPUT;
	wire hMode   = paddr == giwp_pkg::OFF_IRQ_TRIGGER_MODE;
	wire hPol    = paddr == giwp_pkg::OFF_IRQ_POLARITY;
	wire hSel    = paddr == giwp_pkg::OFF_IRQ_CHANNEL_SEL;
	wire hIen    = paddr == giwp_pkg::OFF_IRQ_ENABLE;
	wire hIenSet = paddr == giwp_pkg::OFF_IRQ_ENABLE_SET;
	wire hIenClr = paddr == giwp_pkg::OFF_IRQ_ENABLE_CLEAR;
	wire hStA    = paddr == giwp_pkg::OFF_IRQ_STATUS_A;
	wire hStB    = paddr == giwp_pkg::OFF_IRQ_STATUS_B;
	wire hIclr   = paddr == giwp_pkg::OFF_IRQ_CLEAR;
	wire hWk     = paddr == giwp_pkg::OFF_WAKE_ENABLE;
	wire hWkSet  = paddr == giwp_pkg::OFF_WAKE_ENABLE_SET;
	wire hWkClr  = paddr == giwp_pkg::OFF_WAKE_ENABLE_CLEAR;
	wire hOd     = paddr == giwp_pkg::OFF_OPEN_DRAIN_SEL;

	wire mapped = hEn | hEnSet | hEnClr | hOe | hOeSet | hOeClr | hOut
		| hOutSet | hOutClr | hPin | hMode | hPol | hSel | hIen | hIenSet
		| hIenClr | hStA | hStB | hIclr | hWk | hWkSet | hWkClr | hOd;

	// Byte strobes; a write with no strobe changes nothing
	wire [31:0] laneMask = {{8{pstrb[3]}}, {8{pstrb[2]}},
		{8{pstrb[1]}}, {8{pstrb[0]}}};
	wire [31:0] wdM = pwdata & laneMask;

	function automatic logic [31:0] mergeWr(input logic [31:0] old,
		input logic [31:0] data, input logic [31:0] mask);
		mergeWr = (old & ~mask) | (data & mask);
	endfunction

	// ------------------------------------------------------------------
	// Port enable, output enable, output data
	// ------------------------------------------------------------------
	wire [31:0] portEn_nxt = hEn ? mergeWr(portEn_r, pwdata, laneMask)
		: hEnSet ? (portEn_r | wdM)
		: hEnClr ? (portEn_r & ~wdM) : portEn_r;
	wire [31:0] outEn_nxt = hOe ? mergeWr(outEn_r, pwdata, laneMask)
		: hOeSet ? (outEn_r | wdM)
		: hOeClr ? (outEn_r & ~wdM) : outEn_r;
	wire [31:0] outData_nxt = hOut ? mergeWr(outData_r, pwdata, laneMask)
		: hOutSet ? (outData_r | wdM)
		: hOutClr ? (outData_r & ~wdM) : outData_r;

	always_ff @(posedge mclk or posedge rst)
		if (rst)
		begin
			portEn_r  <= PORT_EN_RESET;
			outEn_r   <= giwp_pkg::RST_ZERO;
			outData_r <= giwp_pkg::RST_ZERO;
		end
		else if (wrAcc)
		begin
			portEn_r  <= portEn_nxt;
			outEn_r   <= outEn_nxt;
			outData_r <= outData_nxt;
		end

	// ------------------------------------------------------------------
	// Interrupt and wake configuration
	// ------------------------------------------------------------------
	wire [31:0] irqEn_nxt = hIen ? mergeWr(irqEn_r, pwdata, laneMask)
		: hIenSet ? (irqEn_r | wdM)
		: hIenClr ? (irqEn_r & ~wdM) : irqEn_r;
	wire [31:0] wakeEn_nxt = hWk ? mergeWr(wakeEn_r, pwdata, laneMask)
		: hWkSet ? (wakeEn_r | wdM)
		: hWkClr ? (wakeEn_r & ~wdM) : wakeEn_r;

	always_ff @(posedge mclk or posedge rst)
		if (rst)
		begin
			trigMode_r  <= giwp_pkg::RST_ZERO;
			polarity_r  <= giwp_pkg::RST_ZERO;
			chanSel_r   <= giwp_pkg::RST_ZERO;
			irqEn_r     <= giwp_pkg::RST_ZERO;
			wakeEn_r    <= giwp_pkg::RST_ZERO;
			openDrain_r <= giwp_pkg::RST_ZERO;
		end
		else if (wrAcc)
		begin
			if (hMode)
				trigMode_r <= mergeWr(trigMode_r, pwdata, laneMask);
			if (hPol)
				polarity_r <= mergeWr(polarity_r, pwdata, laneMask);
			if (hSel)
				chanSel_r <= mergeWr(chanSel_r, pwdata, laneMask);
			if (hOd)
				openDrain_r <= mergeWr(openDrain_r, pwdata, laneMask);
			irqEn_r  <= irqEn_nxt;
			wakeEn_r <= wakeEn_nxt;
		end

	// ------------------------------------------------------------------
	// Edge detectors and pending flops
	// ------------------------------------------------------------------
	// Detection uses only pinIn, never the enables, so it runs for any
	// pin whatever its port function or direction.
	wire [31:0] clrBits  = (wrAcc & hIclr) ? wdM : 32'h0000_0000;
	wire [31:0] riseEdge = pinIn & ~pinPrev_r;
	wire [31:0] fallEdge = ~pinIn & pinPrev_r;
	wire [31:0] edgeSel  = (polarity_r & riseDet_r)
		| (~polarity_r & fallDet_r);
	wire [31:0] levelSel = (polarity_r & pinIn)
		| (~polarity_r & ~pinIn);
	wire [31:0] trigHit  = (trigMode_r & edgeSel)
		| (~trigMode_r & levelSel);
	wire [31:0] setPend  = trigHit & irqEn_r;

	// Set wins over clear so an edge in the clearing cycle is kept.
	always_ff @(posedge mclk or posedge rst)
		if (rst)
		begin
			pinPrev_r <= giwp_pkg::RST_ZERO;
			riseDet_r <= giwp_pkg::RST_ZERO;
			fallDet_r <= giwp_pkg::RST_ZERO;
			pending_r <= giwp_pkg::RST_ZERO;
		end
		else
		begin
			pinPrev_r <= pinIn;
			riseDet_r <= riseEdge | (riseDet_r & ~clrBits);
			fallDet_r <= fallEdge | (fallDet_r & ~clrBits);
			pending_r <= setPend | (pending_r & ~clrBits);
		end

	wire [31:0] statusA = pending_r & ~chanSel_r;
	wire [31:0] statusB = pending_r & chanSel_r;

	assign irqChanA = |statusA;
	assign irqChanB = |statusB;

	// ------------------------------------------------------------------
	// Wake request
	// ------------------------------------------------------------------
	// Wake looks only at latched edges, never at level mode.
	wire wakeReq_nxt = |(wakeEn_r & edgeSel);

	always_ff @(posedge mclk or posedge rst)
		if (rst)
			wakeReq_r <= 1'b0;
		else
			wakeReq_r <= wakeReq_nxt;

	assign wakeReq = wakeReq_r;

	// ------------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------------
	// Open drain only exists on the low half of the first instance;
	// there a one releases the pin rather than driving it high.
	wire [31:0] odEff  = FIRST_PORT ? (openDrain_r & giwp_pkg::OPEN_DRAIN_MASK)
		: giwp_pkg::RST_ZERO;
	wire [31:0] drvEn  = portEn_r & outEn_r;
	wire [31:0] pinOe_nxt = drvEn & ~(odEff & outData_r);

	always_ff @(posedge mclk or posedge rst)
		if (rst)
		begin
			pinOut_r <= giwp_pkg::RST_ZERO;
			pinOe_r  <= giwp_pkg::RST_ZERO;
		end
		else
		begin
			pinOut_r <= outData_r;
			pinOe_r  <= pinOe_nxt;
		end

	assign pinOut = pinOut_r;
	assign pinOe  = pinOe_r;

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	// Write-only registers read as zero.
	wire [31:0] rdMux =
		({32{hEn}}   & portEn_r)    |
		({32{hOe}}   & outEn_r)     |
		({32{hOut}}  & outData_r)   |
		({32{hPin}}  & pinIn)       |
		({32{hMode}} & trigMode_r)  |
		({32{hPol}}  & polarity_r)  |
		({32{hSel}}  & chanSel_r)   |
		({32{hIen}}  & irqEn_r)     |
		({32{hStA}}  & statusA)     |
		({32{hStB}}  & statusB)     |
		({32{hWk}}   & wakeEn_r)    |
		({32{hOd}}   & openDrain_r);

	// Read data is caught in the setup cycle so prdata is a flop output.
	always_ff @(posedge mclk or posedge rst)
		if (rst)
			prdata_r <= giwp_pkg::RST_ZERO;
		else if (setupPh & ~pwrite)
			prdata_r <= rdMux;

	assign prdata  = prdata_r;
	assign pready  = 1'b1;
	assign pslverr = accessPh & ~mapped;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	a_out_clear_bits: assert property (
		(wrAcc && hOutClr) |=> ((outData_r & $past(wdM)) == 32'h0))
		else $error("output clear left a bit set");

	a_pin_read_live: assert property (
		(setupPh && !pwrite && hPin) |=> (prdata == $past(pinIn)))
		else $error("pin input read mismatch");

	a_pend_needs_en: assert property (
		((pending_r & ~$past(pending_r) & ~$past(irqEn_r)) == 32'h0))
		else $error("pending set without enable");

	a_pend_kept: assert property (
		((~$past(clrBits) & $past(pending_r) & ~pending_r) == 32'h0))
		else $error("pending dropped without clear");

	a_ien_set_bits: assert property (
		(wrAcc && hIenSet) |=> ((irqEn_r & $past(wdM)) == $past(wdM)))
		else $error("enable set failed");

	a_iclr_clears: assert property (
		(wrAcc && hIclr) |=>
		((pending_r & $past(clrBits) & ~$past(setPend)) == 32'h0))
		else $error("irq clear left pending");

	a_chan_a_line: assert property (
		((setPend & ~chanSel_r) != 32'h0) |=> irqChanA)
		else $error("channel A not raised");

	a_wake_edge: assert property (
		wakeReq == $past(wakeReq_nxt))
		else $error("wake request mismatch");

	a_drive_gate: assert property (
		((pinOe & ~$past(drvEn)) == 32'h0))
		else $error("pin driven while disabled");

	a_ien_clr_bits: assert property (
		(wrAcc && hIenClr) |=> ((irqEn_r & $past(wdM)) == 32'h0))
		else $error("enable clear failed");

	a_wake_set_bits: assert property (
		(wrAcc && hWkSet) |=> ((wakeEn_r & $past(wdM)) == $past(wdM)))
		else $error("wake enable set failed");

	a_wake_clr_bits: assert property (
		(wrAcc && hWkClr) |=> ((wakeEn_r & $past(wdM)) == 32'h0))
		else $error("wake enable clear failed");

	a_chan_b_line: assert property (
		((setPend & chanSel_r) != 32'h0) |=> irqChanB)
		else $error("channel B not raised");

	a_pend_sets: assert property (
		(setPend != 32'h0) |=>
		((pending_r & $past(setPend)) == $past(setPend)))
		else $error("enabled trigger not latched");

	a_rise_rearm: assert property (
		(wrAcc && hIclr) |=>
		((riseDet_r & $past(clrBits) & ~$past(riseEdge)) == 32'h0))
		else $error("rise detector not cleared");

	a_fall_rearm: assert property (
		(wrAcc && hIclr) |=>
		((fallDet_r & $past(clrBits) & ~$past(fallEdge)) == 32'h0))
		else $error("fall detector not cleared");

	a_od_low_only: assert property (
		(((pinOe ^ $past(drvEn)) & ~giwp_pkg::OPEN_DRAIN_MASK) == 32'h0))
		else $error("open drain on upper pin");

	// Covers for the main scenarios
	c_chan_b_irq: cover property (!irqChanB ##1 irqChanB);
	c_wake_raise: cover property (!wakeReq ##1 wakeReq);
	c_clear_write: cover property (wrAcc && hIclr && (pending_r != 32'h0));
	c_bad_addr: cover property (pslverr);
	c_edge_rearm: cover property (wrAcc && hIclr && (riseDet_r != 32'h0));

endmodule

`default_nettype wire

// ===== giwp_pin_model.sv
/*
 * Pin-side partner of the port: resolves each pin from the port's drive
 * and the level that the outside world puts on it.
 * Assumes the bench sets the outside level between clock edges.
 */
`timescale 1ns/100ps
`default_nettype none

module giwp_pin_model (
	input  wire logic [31:0] pinOut,
	input  wire logic [31:0] pinOe,
	input  wire logic [31:0] extLevel,
	output logic      [31:0] pinIn
);
	// --------------------------------------------------------------
	// Wire resolution
	// --------------------------------------------------------------
	// Released pins follow the outside level, never the last driven one
	assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule

`default_nettype wire

// ===== giwp_port_tb.sv
/*
 * Self-checking bench for the interrupt and wake capable port.
 * Assumes the pin model above and zero-wait APB answers from the port.
 */
`timescale 1ns/100ps
`default_nettype none

module giwp_port_tb;
	logic        mclk, rst, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic        pready, pslverr, irqChanA, irqChanB, wakeReq;
	logic [31:0] prdata, pinIn, pinOut, pinOe, extLevel, rd;
	logic        errSeen;
	int          error_cnt, comparisons, cycles;
	logic [7:0]  zOff [9] = '{giwp_pkg::OFF_OUTPUT_ENABLE,
		giwp_pkg::OFF_OUTPUT_DATA, giwp_pkg::OFF_IRQ_TRIGGER_MODE,
		giwp_pkg::OFF_IRQ_POLARITY, giwp_pkg::OFF_IRQ_CHANNEL_SEL,
		giwp_pkg::OFF_IRQ_ENABLE, giwp_pkg::OFF_IRQ_STATUS_A,
		giwp_pkg::OFF_WAKE_ENABLE, giwp_pkg::OFF_OPEN_DRAIN_SEL};

	giwp_port DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
		.irqChanA(irqChanA), .irqChanB(irqChanB), .wakeReq(wakeReq));

	giwp_pin_model pins (.pinOut(pinOut), .pinOe(pinOe),
		.extLevel(extLevel), .pinIn(pinIn));

	// --------------------------------------------------------------
	// Clock, timeout and report
	// --------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic wrap_up();
		$display("TB: %0d comparisons, %0d errors", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Whole run needs well under 2000 cycles
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			error_cnt++;
			wrap_up();
		end
	end

	// --------------------------------------------------------------
	// APB master and compare helpers
	// --------------------------------------------------------------
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= 4'hF;
		@(posedge mclk);
		penable <= 1'b1;
		// No wait count assumed; only the bench timeout ends a hang
		do
		begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		errSeen = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rdchk(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, e, rd);
	endtask

	// --------------------------------------------------------------
	// Test sequence
	// --------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		pstrb = 4'h0;
		extLevel = 32'h0000_0000;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;

		rdchk("portEnable", giwp_pkg::OFF_PORT_ENABLE, 32'hFF00_FFFF);
		foreach (zOff[i])
			rdchk("resetZero", zOff[i], 32'h0000_0000);
		rdchk("clearReadsZero", giwp_pkg::OFF_OUTPUT_CLEAR, 32'h0);
		$display("TB: reset test done");

		apb(1'b1, giwp_pkg::OFF_PORT_ENABLE, 32'hFFFF_FFFF);
		apb(1'b1, giwp_pkg::OFF_OUTPUT_ENABLE, 32'hFFFF_FFFF);
		apb(1'b1, giwp_pkg::OFF_OUTPUT_DATA, 32'hA5A5_5A5A);
		apb(1'b1, giwp_pkg::OFF_OUTPUT_CLEAR, 32'h0000_00FF);
		rdchk("outData", giwp_pkg::OFF_OUTPUT_DATA, 32'hA5A5_5A00);
		repeat (3) @(posedge mclk);
		chk("pinOe", 32'hFFFF_FFFF, pinOe);
		chk("pinOut", 32'hA5A5_5A00, pinOut);
		rdchk("pinInput", giwp_pkg::OFF_PIN_INPUT, 32'hA5A5_5A00);
		apb(1'b1, giwp_pkg::OFF_OPEN_DRAIN_SEL, 32'hFFFF_FFFF);
		repeat (3) @(posedge mclk);
		chk("pinOeDrain", 32'hFFFF_A5FF, pinOe);
		apb(1'b1, giwp_pkg::OFF_OPEN_DRAIN_SEL, 32'h0000_0000);
		extLevel <= 32'h1234_5600;
		apb(1'b1, giwp_pkg::OFF_OUTPUT_ENABLE, 32'h0000_0000);
		repeat (3) @(posedge mclk);
		chk("pinOeOff", 32'h0000_0000, pinOe);
		rdchk("pinFloat", giwp_pkg::OFF_PIN_INPUT, 32'h1234_5600);
		apb(1'b1, giwp_pkg::OFF_PORT_ENABLE_CLR, 32'hFFFF_FFFF);
		rdchk("portEnClr", giwp_pkg::OFF_PORT_ENABLE, 32'h0000_0000);
		// Set and clear paths of the other registers, then pins 3..2 are driven
		apb(1'b1, giwp_pkg::OFF_OUTPUT_SET, 32'h0000_00F0);
		rdchk("outSet", giwp_pkg::OFF_OUTPUT_DATA, 32'hA5A5_5AF0);
		apb(1'b1, giwp_pkg::OFF_OUTPUT_ENABLE_SET, 32'h0000_000F);
		apb(1'b1, giwp_pkg::OFF_OUTPUT_ENABLE_CLR, 32'h0000_0003);
		rdchk("oeSetClr", giwp_pkg::OFF_OUTPUT_ENABLE, 32'h0000_000C);
		apb(1'b1, giwp_pkg::OFF_PORT_ENABLE_SET, 32'h0000_00FF);
		rdchk("portEnSet", giwp_pkg::OFF_PORT_ENABLE, 32'h0000_00FF);
		repeat (3) @(posedge mclk);
		chk("pinOeBoth", 32'h0000_000C, pinOe);
		apb(1'b1, giwp_pkg::OFF_OUTPUT_ENABLE, 32'h0000_0000);
		apb(1'b1, giwp_pkg::OFF_PORT_ENABLE, 32'h0000_0000);
		apb(1'b0, 8'h5C, 32'h0000_0000);
		chk("unmappedData", 32'h0000_0000, rd);
		chk("unmappedErr", 32'h0000_0001, {31'h0, errSeen});
		$display("TB: output test done");

		// Software order: disable, clear, mode, polarity, channel, enable
		apb(1'b1, giwp_pkg::OFF_IRQ_ENABLE_CLEAR, 32'hFFFF_FFFF);
		apb(1'b1, giwp_pkg::OFF_IRQ_CLEAR, 32'hFFFF_FFFF);
		apb(1'b1, giwp_pkg::OFF_IRQ_TRIGGER_MODE, 32'h0000_000B);
		apb(1'b1, giwp_pkg::OFF_IRQ_POLARITY, 32'h0000_0025);
		apb(1'b1, giwp_pkg::OFF_IRQ_CHANNEL_SEL, 32'h0000_0012);
		apb(1'b1, giwp_pkg::OFF_IRQ_ENABLE_SET, 32'h0000_0017);
		rdchk("irqEnable", giwp_pkg::OFF_IRQ_ENABLE, 32'h0000_0017);
		rdchk("lowLevelB", giwp_pkg::OFF_IRQ_STATUS_B, 32'h0000_0010);
		chk("lineB", 32'h0000_0001, {31'h0, irqChanB});
		chk("lineA", 32'h0000_0000, {31'h0, irqChanA});
		@(posedge mclk) extLevel <= 32'h1234_560F;
		repeat (4) @(posedge mclk);
		@(posedge mclk) extLevel <= 32'h1234_560D;
		repeat (4) @(posedge mclk);
		rdchk("statusA", giwp_pkg::OFF_IRQ_STATUS_A, 32'h0000_0005);
		rdchk("statusB", giwp_pkg::OFF_IRQ_STATUS_B, 32'h0000_0012);
		apb(1'b1, giwp_pkg::OFF_IRQ_ENABLE_CLEAR, 32'hFFFF_FFFF);
		apb(1'b1, giwp_pkg::OFF_IRQ_STATUS_A, 32'hFFFF_FFFF);
		rdchk("heldA", giwp_pkg::OFF_IRQ_STATUS_A, 32'h0000_0005);
		chk("lineHeld", 32'h0000_0001, {31'h0, irqChanA});
		apb(1'b1, giwp_pkg::OFF_IRQ_CLEAR, 32'h0000_0001);
		rdchk("clearOne", giwp_pkg::OFF_IRQ_STATUS_A, 32'h0000_0004);
		apb(1'b1, giwp_pkg::OFF_IRQ_ENABLE_SET, 32'h0000_0005);
		// Pin 0 stays high: a stale rise detector would set it now
		rdchk("armedIdle", giwp_pkg::OFF_IRQ_STATUS_A, 32'h0000_0004);
		@(posedge mclk) extLevel <= 32'h1234_560C;
		repeat (4) @(posedge mclk);
		@(posedge mclk) extLevel <= 32'h1234_560D;
		repeat (4) @(posedge mclk);
		rdchk("rearmed", giwp_pkg::OFF_IRQ_STATUS_A, 32'h0000_0005);
		apb(1'b1, giwp_pkg::OFF_IRQ_CLEAR, 32'h0000_0004);
		rdchk("levelHolds", giwp_pkg::OFF_IRQ_STATUS_A, 32'h0000_0005);
		apb(1'b1, giwp_pkg::OFF_IRQ_ENABLE, 32'h0000_0000);
		rdchk("irqEnOff", giwp_pkg::OFF_IRQ_ENABLE, 32'h0000_0000);
		apb(1'b1, giwp_pkg::OFF_IRQ_CLEAR, 32'hFFFF_FFFF);
		rdchk("clearAllA", giwp_pkg::OFF_IRQ_STATUS_A, 32'h0000_0000);
		rdchk("clearAllB", giwp_pkg::OFF_IRQ_STATUS_B, 32'h0000_0000);
		chk("linesLow", 32'h0000_0000, {30'h0, irqChanA, irqChanB});
		$display("TB: interrupt test done");

		// Wake: polarity already rising on pin 5, clear, then enable
		apb(1'b1, giwp_pkg::OFF_IRQ_CLEAR, 32'h0000_0020);
		apb(1'b1, giwp_pkg::OFF_WAKE_ENABLE_SET, 32'h0000_0020);
		rdchk("wakeEnSet", giwp_pkg::OFF_WAKE_ENABLE, 32'h0000_0020);
		chk("wakeIdle", 32'h0000_0000, {31'h0, wakeReq});
		@(posedge mclk) extLevel <= 32'h1234_562D;
		repeat (4) @(posedge mclk);
		chk("wakeRaised", 32'h0000_0001, {31'h0, wakeReq});
		apb(1'b1, giwp_pkg::OFF_WAKE_ENABLE_CLEAR, 32'h0000_0020);
		rdchk("wakeEnClr", giwp_pkg::OFF_WAKE_ENABLE, 32'h0000_0000);
		repeat (3) @(posedge mclk);
		chk("wakeDropped", 32'h0000_0000, {31'h0, wakeReq});
		// Detector is still latched, so a direct re-enable wakes again
		apb(1'b1, giwp_pkg::OFF_WAKE_ENABLE, 32'h0000_0020);
		repeat (3) @(posedge mclk);
		chk("wakeLatched", 32'h0000_0001, {31'h0, wakeReq});
		apb(1'b1, giwp_pkg::OFF_IRQ_CLEAR, 32'h0000_0020);
		repeat (3) @(posedge mclk);
		chk("wakeCleared", 32'h0000_0000, {31'h0, wakeReq});
		apb(1'b1, giwp_pkg::OFF_WAKE_ENABLE, 32'h0000_0000);
		$display("TB: wake test done");
		wrap_up();
	end
endmodule

`default_nettype wire
